// File: design/wdrt_top.sv
// Watchdog reset timer with bit-addressable control register
// Overview of operation
// - While enabled, a missed refresh within the timeout forces system reset
// - Enable bit zero disables; no watchdog reset is ever generated then
// - Timing element is a 16-bit counter driven through a prescaler
// - Select codes 000..111 give 16,32,64,128,256,512,1024,2048 ms
// - A watchdog timeout sets the timeout status flag, bit 1
// - Status flag survives watchdog reset; only external reset clears it
// - Setting enable bit 0 starts with counters cleared
// - Register resets to zero, disabled; single bits writable by address
`timescale 1ns/100ps
`include "wdrt_cfg.svh"
module wdrt_top #(
    parameter int TICK_CYC = `WDRT_TICK_CYC,
    parameter int BASE_TICKS = `WDRT_BASE_TICKS,
    parameter int RST_PULSE_CYC = `WDRT_RST_PULSE_CYC
) (
    input wire logic i_sys_clk, // 20 MHz system clock
    input wire logic i_rst_n, // External hardware reset, active low
    input wire wdrt_pkg::wdrt_sfr_req_t i_req, // Register access
    output logic [7:0] o_sfr_rdata, // Read data, one cycle after rd
    output wdrt_pkg::wdrt_ctrl_t o_ctrl, // Control register contents
    output logic o_wd_reset // System reset request, active high
);
    import wdrt_pkg::*;

    localparam int CW = `WDRT_CNT_W;
    localparam int PW = (RST_PULSE_CYC > 1) ? $clog2(RST_PULSE_CYC) : 1;

    wdrt_ctrl_t ctrl;
    wdrt_ctrl_t wr_val;
    wdrt_state_t state;
    logic [CW-1:0] count;
    logic [CW-1:0] term;
    logic [PW-1:0] pulse_cnt;
    logic wr_hit;
    logic tick;
    logic timeout;
    logic refresh;
    logic restart;
    logic sel_moved;

    // Last tick count of a selected period; 2048 ms just fits 16 bits
    function automatic logic [CW-1:0] term_of(input logic [2:0] sel);
        logic [CW:0] span;
        span = (CW+1)'(BASE_TICKS) << sel;
        term_of = CW'(span - 1'b1);
    endfunction : term_of

    assign term = term_of(ctrl.timeout_select_field);

    always_comb
    begin
        wr_val = ctrl;
        wr_hit = 1'b0;
        if (i_req.wr && i_req.addr == `WDRT_CTRL_ADDR)
        begin
            wr_val = wdrt_ctrl_t'(i_req.wdata);
            wr_hit = 1'b1;
        end
        else if (i_req.bit_wr
            && i_req.bit_addr[7:3] == 5'(`WDRT_CTRL_ADDR >> 3))
        begin
            wr_val[i_req.bit_addr[2:0]] = i_req.bit_val;
            wr_hit = 1'b1;
        end
    end

    // second bit counts only after first
    assign refresh = wr_hit && wr_val.refresh_second_bit
        && ctrl.refresh_first_bit && state != WDRT_WDRST;
    // enable going from clear to set
    assign restart = wr_hit && wr_val.wd_enable_bit && !ctrl.wd_enable_bit
        && state != WDRT_WDRST;
    assign timeout = ctrl.wd_enable_bit && state == WDRT_RUN && tick
        && count >= term;

    // Control register; timeout wins over a write in the same cycle
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            ctrl <= wdrt_ctrl_t'(`WDRT_CTRL_RESET);
        end
        else if (timeout)
        begin
            // flag set; kept through own reset
            ctrl <= wdrt_ctrl_t'(`WDRT_CTRL_RESET);
            ctrl.timeout_status_flag <= 1'b1;
        end
        else if (wr_hit && state != WDRT_WDRST)
        begin
            ctrl.timeout_select_field <= wr_val.timeout_select_field;
            ctrl.wd_enable_bit <= wr_val.wd_enable_bit;
            ctrl.refresh_first_bit <= refresh ? 1'b0
                : wr_val.refresh_first_bit;
            // lone second bit does not stick
            ctrl.refresh_second_bit <= 1'b0;
        end
    end

    // Sequencer; during the reset pulse the core is held, writes dropped
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            state <= WDRT_IDLE;
        end
        else
        begin
            unique case (state)
                WDRT_IDLE:
                    state <= restart ? WDRT_RUN : WDRT_IDLE;
                WDRT_RUN:
                    if (timeout)
                        state <= WDRT_WDRST;
                    // clearing enable stops timing
                    // A re-enable on the very next edge must not strand
                    // the enable bit set with the sequencer idle
                    else if (!ctrl.wd_enable_bit && !restart)
                        state <= WDRT_IDLE;
                WDRT_WDRST:
                    if (pulse_cnt == PW'(RST_PULSE_CYC - 1))
                        state <= WDRT_IDLE;
                default:
                    state <= WDRT_IDLE;
            endcase
        end
    end

    wdrt_prescaler #(
        .DIV(TICK_CYC)
    ) u_prescaler (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_clear(state != WDRT_RUN || restart || refresh),
        .o_tick(tick)
    );

    // tick counter, saturating at its width
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n || state != WDRT_RUN || restart || refresh || timeout)
            count <= '0;
        else if (tick && count != '1)
            count <= count + 1'b1;
    end

    // Reset pulse width counter
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n || state != WDRT_WDRST)
            pulse_cnt <= '0;
        else
            pulse_cnt <= pulse_cnt + 1'b1;
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
            o_wd_reset <= 1'b0;
        else if (timeout)
            o_wd_reset <= 1'b1;
        else if (state == WDRT_WDRST && pulse_cnt == PW'(RST_PULSE_CYC - 1))
            o_wd_reset <= 1'b0;
    end

    // Registered read port; unused bit 4 reads zero
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            o_sfr_rdata <= 8'h00;
            o_ctrl <= wdrt_ctrl_t'(`WDRT_CTRL_RESET);
        end
        else
        begin
            o_sfr_rdata <= (i_req.rd && i_req.addr == `WDRT_CTRL_ADDR)
                ? (ctrl & `WDRT_CTRL_RD_MASK) : 8'h00;
            o_ctrl <= ctrl & `WDRT_CTRL_RD_MASK;
        end
    end

    // Check helper: a select change mid-run may leave the counter above
    // the new terminal until the next tick, which is legal
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n || state != WDRT_RUN || restart)
            sel_moved <= 1'b0;
        else if (wr_hit
            && wr_val.timeout_select_field != ctrl.timeout_select_field)
            sel_moved <= 1'b1;
    end

    // Checks
    sequence s_wd_pulse;
        o_wd_reset [*8];
    endsequence

    property p_timeout_reset;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        timeout |=> o_wd_reset && ctrl.timeout_status_flag
            && !ctrl.wd_enable_bit;
    endproperty
    a_timeout_reset: assert property (p_timeout_reset)
        else $error("timeout did not raise reset and flag");

    property p_pulse_len;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        $rose(o_wd_reset) |-> s_wd_pulse;
    endproperty
    a_pulse_len: assert property (p_pulse_len)
        else $error("watchdog reset pulse too short");

    property p_no_reset_disabled;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (!ctrl.wd_enable_bit && state != WDRT_WDRST) |=> !o_wd_reset;
    endproperty
    a_no_reset_disabled: assert property (p_no_reset_disabled)
        else $error("reset raised while disabled");

    property p_count_bound;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        state == WDRT_RUN && !sel_moved
            |-> count <= term;
    endproperty
    a_count_bound: assert property (p_count_bound)
        else $error("counter ran past terminal count");

    property p_min_code_period;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        restart && wr_val.timeout_select_field == 3'h0
            |=> !o_wd_reset [*8];
    endproperty
    a_min_code_period: assert property (p_min_code_period)
        else $error("timeout came too early after start");

    property p_flag_sticky;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        ctrl.timeout_status_flag |=> ctrl.timeout_status_flag;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("status flag lost without external reset");

    property p_restart_clear;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        restart |=> count == '0 && state == WDRT_RUN;
    endproperty
    a_restart_clear: assert property (p_restart_clear)
        else $error("enable did not start with clear counter");

    property p_refresh;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        refresh && !timeout |=> count == '0
            && !ctrl.refresh_first_bit && !ctrl.refresh_second_bit;
    endproperty
    a_refresh: assert property (p_refresh)
        else $error("refresh did not clear counter and bits");

    property p_lone_second;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        wr_hit && !ctrl.refresh_first_bit && state == WDRT_RUN
            && !timeout && !restart && tick == 1'b0
            |=> count == $past(count);
    endproperty
    a_lone_second: assert property (p_lone_second)
        else $error("unordered refresh bits touched the counter");
endmodule : wdrt_top

// File: design/wdrt_cfg.svh
// Watchdog reset timer constants: register map, field positions, timing
`ifndef WDRT_CFG_SVH
`define WDRT_CFG_SVH
`define WDRT_CTRL_ADDR 8'hC0
`define WDRT_CTRL_RESET 8'h00
`define WDRT_CTRL_RD_MASK 8'hEF
`define WDRT_BIT_EN 3'h0
`define WDRT_BIT_STAT 3'h1
`define WDRT_BIT_REF2 3'h2
`define WDRT_BIT_REF1 3'h3
`define WDRT_CNT_W 16
`define WDRT_CLK_HZ 20000000
`define WDRT_BASE_TIMEOUT_MS 16
`define WDRT_BASE_TICKS 512
`define WDRT_TICK_CYC \
    (`WDRT_CLK_HZ / 1000 * `WDRT_BASE_TIMEOUT_MS / `WDRT_BASE_TICKS)
`define WDRT_RST_PULSE_CYC 16
`endif

// File: design/wdrt_pkg.sv
// Watchdog reset timer types
package wdrt_pkg;
    // Control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic [2:0] timeout_select_field;
        logic spare;
        logic refresh_first_bit;
        logic refresh_second_bit;
        logic timeout_status_flag;
        logic wd_enable_bit;
    } wdrt_ctrl_t;

    // Special function register access from the core
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic bit_wr;
        logic [7:0] bit_addr;
        logic bit_val;
    } wdrt_sfr_req_t;

    typedef enum logic [1:0] {
        WDRT_IDLE = 2'h0,
        WDRT_RUN = 2'h1,
        WDRT_WDRST = 2'h3
    } wdrt_state_t;
endpackage : wdrt_pkg

// File: design/wdrt_prescaler.sv
// Prescaler producing one tick pulse every DIV clocks
`timescale 1ns/100ps
module wdrt_prescaler #(
    parameter int DIV = 625
) (
    input wire logic i_sys_clk, // System clock
    input wire logic i_rst_n, // Synchronous reset, active low
    input wire logic i_clear, // Restart the division from zero
    output logic o_tick // One-cycle tick
);
    localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [W-1:0] LAST = W'(DIV - 1);
    logic [W-1:0] div_cnt;

    // Divider; a clear also drops a pending tick so a restart is full length
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n || i_clear)
        begin
            div_cnt <= '0;
            o_tick <= 1'b0;
        end
        else
        begin
            o_tick <= (div_cnt == LAST);
            div_cnt <= (div_cnt == LAST) ? '0 : div_cnt + 1'b1;
        end
    end
endmodule : wdrt_prescaler

// File: tb/wdrt_tb.sv
// Self-checking bench for the watchdog reset timer
`timescale 1ns/100ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failures++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
    import wdrt_pkg::*;
    // Short counts keep the longest timeout near a thousand cycles
    localparam int TICK = 4;
    localparam int BASE = 2;
    localparam int PULSE = 16;
    logic i_sys_clk = 1'b0;
    logic i_rst_n = 1'b0;
    wdrt_sfr_req_t req = '0;
    logic [7:0] rdata;
    wdrt_ctrl_t ctrl;
    logic wd_rst;
    int rst_cnt = 0;
    int seen0;
    int failures = 0;
    int compares = 0;
    int n;
    logic [7:0] d;

    wdrt_top #(.TICK_CYC(TICK), .BASE_TICKS(BASE), .RST_PULSE_CYC(PULSE))
    dut_u (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_req(req),
        .o_sfr_rdata(rdata),
        .o_ctrl(ctrl),
        .o_wd_reset(wd_rst)
    );

    // 20 MHz clock
    always #25 i_sys_clk = ~i_sys_clk;

    // Running count of cycles with the reset request high
    always @(posedge i_sys_clk)
    begin
        if (wd_rst === 1'b1)
            rst_cnt <= rst_cnt + 1;
    end

    task automatic cyc(input int k);
        repeat (k) @(posedge i_sys_clk);
        #1;
    endtask : cyc

    task automatic wr_byte(input logic [7:0] a, input logic [7:0] v);
        @(posedge i_sys_clk);
        req.wr <= 1'b1;
        req.addr <= a;
        req.wdata <= v;
        @(posedge i_sys_clk);
        req.wr <= 1'b0;
    endtask : wr_byte

    task automatic wr_bit(input logic [7:0] a, input logic v);
        @(posedge i_sys_clk);
        req.bit_wr <= 1'b1;
        req.bit_addr <= a;
        req.bit_val <= v;
        @(posedge i_sys_clk);
        req.bit_wr <= 1'b0;
    endtask : wr_bit

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge i_sys_clk);
        req.rd <= 1'b1;
        req.addr <= a;
        @(posedge i_sys_clk);
        req.rd <= 1'b0;
        #1;
        v = rdata;
    endtask : rd

    task automatic ext_reset();
        @(posedge i_sys_clk);
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        #1;
    endtask : ext_reset

    // Bounded wait for the reset request; returns cycles waited
    task automatic wait_rst(output int k);
        k = 0;
        while (wd_rst !== 1'b1 && k < 5000)
        begin
            @(posedge i_sys_clk);
            #1;
            k++;
        end
    endtask : wait_rst

    task automatic t_reset();
        ext_reset();
        cyc(1);
        `CHK(ctrl, 8'h00)
        rd(8'hC0, d);
        `CHK(d, 8'h00)
        wr_byte(8'hC0, 8'h10);
        rd(8'hC5, d);
        `CHK(d, 8'h00)
        `CHK(ctrl, 8'h00)
        wr_bit(8'hC1, 1'b1);
        wr_bit(8'hC0, 1'b1);
        cyc(2);
        `CHK(ctrl, 8'h01)
        rd(8'hC0, d);
        `CHK(d, 8'h01)
        wr_bit(8'hC0, 1'b0);
        cyc(2);
    endtask : t_reset

    task automatic t_timeouts();
        int p;
        for (int s = 0; s < 8; s++)
        begin
            wr_byte(8'hC0, {s[2:0], 5'h01});
            wait_rst(n);
            `CHK(n, (BASE << s) * TICK + 1)
            p = 0;
            while (wd_rst === 1'b1 && p < 100)
            begin
                p++;
                @(posedge i_sys_clk);
                #1;
            end
            `CHK(p, PULSE)
            cyc(1);
            `CHK(ctrl, 8'h02)
            rd(8'hC0, d);
            `CHK(d, 8'h02)
        end
        wr_bit(8'hC1, 1'b0);
        wr_byte(8'hC0, 8'h00);
        cyc(2);
        `CHK(ctrl, 8'h02)
        ext_reset();
        cyc(1);
        `CHK(ctrl, 8'h00)
    endtask : t_timeouts

    task automatic t_disabled();
        seen0 = rst_cnt;
        cyc(300);
        wr_byte(8'hC0, 8'h21);
        cyc(8);
        wr_byte(8'hC0, 8'h20);
        cyc(100);
        `CHK(rst_cnt, seen0)
    endtask : t_disabled

    task automatic t_refresh();
        wr_byte(8'hC0, 8'h41);
        seen0 = rst_cnt;
        repeat (6)
        begin
            cyc(12);
            wr_bit(8'hC3, 1'b1);
            cyc(2);
            `CHK(ctrl.refresh_first_bit, 1'b1)
            wr_bit(8'hC2, 1'b1);
            cyc(2);
            `CHK(ctrl[3:2], 2'b00)
        end
        `CHK(rst_cnt, seen0)
        wr_byte(8'hC0, 8'h40);
        // A lone second refresh bit must not restart the count
        wr_byte(8'hC0, 8'h21);
        cyc(6);
        wr_bit(8'hC2, 1'b1);
        wait_rst(n);
        `CHK(n, (BASE << 1) * TICK + 1 - 8)
        cyc(20);
    endtask : t_refresh

    task automatic t_restart();
        wr_byte(8'hC0, 8'h21);
        cyc(10);
        wr_byte(8'hC0, 8'h20);
        wr_byte(8'hC0, 8'h21);
        wait_rst(n);
        `CHK(n, (BASE << 1) * TICK + 1)
        cyc(20);
        // Disable and re-enable on consecutive edges, strobe held high
        wr_byte(8'hC0, 8'h21);
        cyc(10);
        @(posedge i_sys_clk);
        req.wr <= 1'b1;
        req.addr <= 8'hC0;
        req.wdata <= 8'h20;
        @(posedge i_sys_clk);
        req.wdata <= 8'h21;
        @(posedge i_sys_clk);
        req.wr <= 1'b0;
        wait_rst(n);
        `CHK(n, (BASE << 1) * TICK + 1)
        cyc(20);
    endtask : t_restart

    task automatic close_out();
        if (failures == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : close_out

    // Main sequence after the opening reset
    initial
    begin
        repeat (2) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        t_reset();
        t_timeouts();
        t_disabled();
        t_refresh();
        t_restart();
        close_out();
    end

    // Hang guard, far above the few thousand cycles the run needs
    initial
    begin
        #(50 * 20000);
        failures++;
        close_out();
    end
endmodule : tb
